// File: inc/trim_regs_pkg.sv
// constants for the channel offset and full-scale trim register bank
package trim_regs_pkg;
   // register map, 4-bit serial address
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFFSET_TRIM_ADDR = 4'h2;
   localparam logic [3:0] FULL_SCALE_TRIM_ADDR = 4'h3;
   localparam int REG_W = 16;
   localparam logic [15:0] OFFSET_TRIM_RESET = 16'h0000;
   localparam logic [15:0] FULL_SCALE_TRIM_RESET = 16'h4000;
   // offset trim fields
   localparam int OFFSET_POLARITY_BIT = 12;
   localparam int OFFSET_MAG_MSB = 11;
   localparam int OFFSET_MAG_W = 12;
   localparam int OFFSET_STORE_W = 13;
   localparam int OFFSET_RES_LSB = 13;
   // full-scale trim fields
   localparam int FULL_SCALE_MAG_MSB = 14;
   localparam int FULL_SCALE_MAG_W = 15;
   localparam int FULL_SCALE_RES_BIT = 15;
   // code range of the trims and the analog values they stand for
   localparam logic [11:0] OFFSET_MAG_MAX_CODE = 12'hFFF;
   localparam int OFFSET_MAX_MV = 45;
   localparam logic [14:0] FULL_SCALE_MAX_CODE = 15'h7FFF;
   localparam logic [14:0] FULL_SCALE_DEFAULT_CODE = 15'h4000;
   localparam int FULL_SCALE_MIN_MV = 600;
   localparam int FULL_SCALE_DEFAULT_MV = 790;
   localparam int FULL_SCALE_MAX_MV = 980;
   // serial frame: 8 command bits then 16 data bits, msb first
   localparam logic [4:0] CMD_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int CMD_READ_BIT = 7;
   localparam logic [15:0] UNMAPPED_READ_VALUE = 16'h0000;
endpackage : trim_regs_pkg

// File: logic/channel_offset_gain_trim_regs.sv
// offset and full-scale trim registers of one channel behind the serial control port
//
// Overview of operation
// - polarity bit one makes the offset negative
// - offset magnitude straight binary, 4095 is 45 mV
// - range code straight binary, 600 to 980 mV
// - range default code 16384, that is 790 mV
`timescale 1ns/1ps
`default_nettype none
module channel_offset_gain_trim_regs (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // serial control port
   input wire logic SCS_N_I,
   input wire logic SCLK_I,
   input wire logic SDI_I,
   output logic SDO_O,
   output logic SDO_OE_N_O,
   // trims applied to the channel
   output logic signed [12:0] OFFSET_TRIM_O,
   output logic [14:0] FULL_SCALE_RANGE_O,
   // raw register contents
   output logic [15:0] OFFSET_TRIM_REG_O,
   output logic [15:0] FULL_SCALE_TRIM_REG_O
);
   logic [1:0] scs_n_sync_r;
   logic [2:0] sclk_sync_r;
   logic [1:0] sdi_sync_r;
   logic sclk_rise;
   logic sclk_fall;
   logic selected;
   logic [4:0] bit_cnt_r;
   logic [23:0] shift_in_r;
   logic [23:0] shift_in_nxt;
   logic [7:0] cmd_r;
   logic [15:0] shift_out_r;
   logic sdo_r;
   logic frame_done;
   logic cmd_done;
   logic out_shift;
   logic [3:0] read_addr;
   logic write_offset;
   logic write_full_scale;
   logic [15:0] read_value;
   logic [12:0] offset_store;
   logic [14:0] full_scale_store;
   logic [12:0] offset_wdata;
   logic [14:0] full_scale_wdata;
   logic [12:0] offset_mag_ext;
   logic signed [12:0] offset_trim_r;
   logic [14:0] full_scale_r;

   // port pins come from the host clock domain: two flops before use
   // select resets high so no frame starts while reset is released
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         scs_n_sync_r <= 2'h3;
      end else begin
         scs_n_sync_r <= {scs_n_sync_r[0], SCS_N_I};
      end
   end

   // third flop on the serial clock gives the edge detector its old value;
   // reset value matches the idle low level so no false edge follows reset
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sclk_sync_r <= 3'h0;
      end else begin
         sclk_sync_r <= {sclk_sync_r[1:0], SCLK_I};
      end
   end

   // data takes the same two flops as the clock, so the bit seen at a
   // detected rising edge is the one the host held around that edge
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sdi_sync_r <= 2'h0;
      end else begin
         sdi_sync_r <= {sdi_sync_r[0], SDI_I};
      end
   end

   assign selected = !scs_n_sync_r[1];
   assign sclk_rise = selected && sclk_sync_r[1] && !sclk_sync_r[2];
   assign sclk_fall = selected && !sclk_sync_r[1] && sclk_sync_r[2];
   assign shift_in_nxt = {shift_in_r[22:0], sdi_sync_r[1]};
   assign frame_done = sclk_rise && (bit_cnt_r == (trim_regs_pkg::FRAME_BITS - 5'h01));
   assign cmd_done = sclk_rise && (bit_cnt_r == (trim_regs_pkg::CMD_BITS - 5'h01));
   assign out_shift = sclk_fall && bit_cnt_r >= trim_regs_pkg::CMD_BITS
      && bit_cnt_r < trim_regs_pkg::FRAME_BITS;
   // address of a read is complete at the last command bit, before cmd_r holds it
   assign read_addr = shift_in_nxt[3:0];

   // bit counter and input shifter; a deselect aborts the frame
   // the count stops at the frame length, so extra bits are ignored
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         bit_cnt_r <= 5'h00;
         shift_in_r <= 24'h000000;
      end else if (!selected) begin
         bit_cnt_r <= 5'h00;
      end else if (sclk_rise && bit_cnt_r != trim_regs_pkg::FRAME_BITS) begin
         bit_cnt_r <= bit_cnt_r + 5'h01;
         shift_in_r <= shift_in_nxt;
      end
   end

   // command byte latched on its eighth bit
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cmd_r <= 8'h00;
      end else if (cmd_done) begin
         cmd_r <= shift_in_nxt[7:0];
      end
   end

   // register writes commit on the last bit of a write frame; a frame cut
   // short by a deselect never reaches this bit, so it writes nothing
   always_comb begin
      write_offset = 1'b0;
      write_full_scale = 1'b0;
      if (frame_done && !cmd_r[trim_regs_pkg::CMD_READ_BIT]) begin
         if (cmd_r[3:0] == trim_regs_pkg::OFFSET_TRIM_ADDR) begin
            write_offset = 1'b1;
         end else if (cmd_r[3:0] == trim_regs_pkg::FULL_SCALE_TRIM_ADDR) begin
            write_full_scale = 1'b1;
         end
      end
   end

   // reserved bits are not stored and read back as zero
   assign offset_wdata = shift_in_nxt[trim_regs_pkg::OFFSET_POLARITY_BIT:0];
   assign full_scale_wdata = shift_in_nxt[trim_regs_pkg::FULL_SCALE_MAG_MSB:0];

   trim_reg_cell #(
      .WIDTH(trim_regs_pkg::OFFSET_STORE_W),
      .RESET_VALUE(trim_regs_pkg::OFFSET_TRIM_RESET[12:0])
   ) offset_cell (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .load_i(write_offset),
      .data_i(offset_wdata),
      .value_o(offset_store)
   );

   trim_reg_cell #(
      .WIDTH(trim_regs_pkg::FULL_SCALE_MAG_W),
      .RESET_VALUE(trim_regs_pkg::FULL_SCALE_TRIM_RESET[14:0])
   ) full_scale_cell (
      .clk_i(MCLK_I),
      .rst_n_i(RST_N_I),
      .load_i(write_full_scale),
      .data_i(full_scale_wdata),
      .value_o(full_scale_store)
   );

   // read-back view with the reserved bits tied low
   assign OFFSET_TRIM_REG_O = {3'h0, offset_store};
   assign FULL_SCALE_TRIM_REG_O = {1'h0, full_scale_store};

   // read mux for the data phase; unmapped addresses read zero
   always_comb begin
      read_value = trim_regs_pkg::UNMAPPED_READ_VALUE;
      if (read_addr == trim_regs_pkg::OFFSET_TRIM_ADDR) begin
         read_value = OFFSET_TRIM_REG_O;
      end else if (read_addr == trim_regs_pkg::FULL_SCALE_TRIM_ADDR) begin
         read_value = FULL_SCALE_TRIM_REG_O;
      end
   end

   // output shifter: loaded after the command byte, shifted on falling edges
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         shift_out_r <= 16'h0000;
      end else if (cmd_done) begin
         shift_out_r <= read_value;
      end else if (out_shift) begin
         shift_out_r <= {shift_out_r[14:0], 1'b0};
      end
   end

   // data pin changes after a falling edge and holds through the next rise
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sdo_r <= 1'b0;
      end else if (out_shift) begin
         sdo_r <= shift_out_r[15];
      end
   end

   assign SDO_O = sdo_r;
   // pin driven only in the data phase of a read frame
   assign SDO_OE_N_O = !(selected && cmd_r[trim_regs_pkg::CMD_READ_BIT]
      && bit_cnt_r >= trim_regs_pkg::CMD_BITS);

   // straight binary magnitude, sign selects polarity of the applied offset
   // a zero magnitude gives zero offset for either polarity
   assign offset_mag_ext = {1'b0, offset_store[trim_regs_pkg::OFFSET_MAG_MSB:0]};
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         offset_trim_r <= 13'sh0000;
      end else if (offset_store[trim_regs_pkg::OFFSET_POLARITY_BIT]) begin
         offset_trim_r <= $signed(13'h0000 - offset_mag_ext);
      end else begin
         offset_trim_r <= $signed(offset_mag_ext);
      end
   end

   // range code passed straight to the channel, default mid-range
   always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         full_scale_r <= trim_regs_pkg::FULL_SCALE_DEFAULT_CODE;
      end else begin
         full_scale_r <= full_scale_store;
      end
   end

   assign OFFSET_TRIM_O = offset_trim_r;
   assign FULL_SCALE_RANGE_O = full_scale_r;
endmodule : channel_offset_gain_trim_regs
`default_nettype wire

// File: logic/trim_reg_cell.sv
// one trim register with reset value and write load
`timescale 1ns/1ps
`default_nettype none
module trim_reg_cell #(
   parameter int WIDTH = 16,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // write port
   input wire logic load_i,
   input wire logic [WIDTH-1:0] data_i,
   // stored value
   output logic [WIDTH-1:0] value_o
);
   logic [WIDTH-1:0] value_r;

   // holds the written value until the next write or reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         value_r <= RESET_VALUE;
      end else if (load_i) begin
         value_r <= data_i;
      end
   end

   assign value_o = value_r;
endmodule : trim_reg_cell
`default_nettype wire

// File: verif/host_model.sv
// host controller driving serial control frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk_i,
   input wire logic sdo_i,
   output logic scs_n_o,
   output logic sclk_o,
   output logic sdi_o
);
   initial begin
      scs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // 24-bit frame, msb first, clock low 5 cycles and high 4 cycles per bit
   task automatic frame(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
      logic [23:0] sh;
      sh = {cmd, wd};
      rd = 16'h0000;
      @(posedge clk_i) scs_n_o <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         @(posedge clk_i) sdi_o <= sh[i];
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b1;
         if (i < 16) rd[i] = sdo_i;
         repeat (4) @(posedge clk_i);
         sclk_o <= 1'b0;
      end
      repeat (4) @(posedge clk_i);
      scs_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      repeat (8) @(posedge clk_i);
   endtask : frame
endmodule : host_model
`default_nettype wire

// File: verif/test_channel_offset_gain_trim_regs.sv
// self-checking bench for the channel trim register bank
`timescale 1ns/1ps
`default_nettype none
module test_channel_offset_gain_trim_regs;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic scs_n, sclk, sdi, sdo, sdo_oe_n;
   logic signed [12:0] offset_trim;
   logic [14:0] full_scale_range;
   logic [15:0] off_reg, fsr_reg, rd;
   int n_fail = 0;
   int n_checks = 0;
   int cycles = 0;
   int oe_low = 0;
   always #4 mclk = ~mclk;
   // cycles in which the data pin is driven
   always @(posedge mclk) begin
      if (sdo_oe_n === 1'b0) begin
         oe_low++;
      end
   end
   host_model i_host (.clk_i(mclk), .sdo_i(sdo), .scs_n_o(scs_n), .sclk_o(sclk), .sdi_o(sdi));
   channel_offset_gain_trim_regs i_dut (.MCLK_I(mclk), .RST_N_I(rst_n), .SCS_N_I(scs_n),
      .SCLK_I(sclk), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_N_O(sdo_oe_n), .OFFSET_TRIM_O(offset_trim),
      .FULL_SCALE_RANGE_O(full_scale_range), .OFFSET_TRIM_REG_O(off_reg), .FULL_SCALE_TRIM_REG_O(fsr_reg));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic t_reset();
      int n0;
      chk("offset reg", 16'h0000, off_reg);
      chk("range reg", 16'h4000, fsr_reg);
      chk("range out", 16'h4000, {1'b0, full_scale_range});
      chk("offset out", 16'h0000, {{3{offset_trim[12]}}, offset_trim});
      n0 = oe_low;
      i_host.frame(8'h83, 16'h0000, rd);
      chk("range read", 16'h4000, rd);
      chk("oe read", 16'h0001, {15'h0000, oe_low - n0 >= 144 && oe_low - n0 <= 160});
      chk("oe idle", 16'h0001, {15'h0000, sdo_oe_n});
   endtask : t_reset
   task automatic t_offset();
      logic [15:0] wv [4] = '{16'h1FFF, 16'h0800, 16'h1000, 16'h0FFF};
      logic [15:0] rv [4] = '{16'h1FFF, 16'h0800, 16'h1000, 16'h0FFF};
      logic [15:0] ov [4] = '{16'hF001, 16'h0800, 16'h0000, 16'h0FFF};
      for (int k = 0; k < 4; k++) begin
         i_host.frame(8'h02, wv[k], rd);
         chk("offset reg", rv[k], off_reg);
         chk("offset out", ov[k], {{3{offset_trim[12]}}, offset_trim});
         i_host.frame(8'h82, 16'h0000, rd);
         chk("offset read", rv[k], rd);
      end
   endtask : t_offset
   task automatic t_range();
      int n0;
      n0 = oe_low;
      i_host.frame(8'h03, 16'h7FFF, rd);
      chk("oe in write", 16'h0000, {15'h0000, oe_low != n0});
      chk("range out", 16'h7FFF, {1'b0, full_scale_range});
      i_host.frame(8'h83, 16'h0000, rd);
      chk("range read", 16'h7FFF, rd);
      i_host.frame(8'h03, 16'h0000, rd);
      chk("range out", 16'h0000, {1'b0, full_scale_range});
      i_host.frame(8'h04, 16'h1234, rd);
      i_host.frame(8'h84, 16'h0000, rd);
      chk("unmapped read", 16'h0000, rd);
      chk("range reg", 16'h0000, fsr_reg);
      chk("offset reg", 16'h0FFF, off_reg);
   endtask : t_range
   task automatic t_rerst();
      rst_n <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("offset reg", 16'h0000, off_reg);
      chk("range out", 16'h4000, {1'b0, full_scale_range});
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("range reg", 16'h4000, fsr_reg);
      chk("offset out", 16'h0000, {{3{offset_trim[12]}}, offset_trim});
      i_host.frame(8'h82, 16'h0000, rd);
      chk("offset read", 16'h0000, rd);
   endtask : t_rerst
   task automatic results();
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : results
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         results();
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset();
      t_offset();
      t_range();
      t_rerst();
      results();
   end
endmodule : test_channel_offset_gain_trim_regs
`default_nettype wire

// File: verif/trim_regs_chk.sv
// port assertions for the channel trim register bank
`timescale 1ns/1ps
`default_nettype none
module trim_regs_chk (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_N_I,
   // watched ports
   input wire logic SCS_N_I,
   input wire logic signed [12:0] OFFSET_TRIM_O,
   input wire logic [14:0] FULL_SCALE_RANGE_O,
   input wire logic [15:0] OFFSET_TRIM_REG_O,
   input wire logic [15:0] FULL_SCALE_TRIM_REG_O
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RST_N_I);
   a_reserved_bits_zero: assert property (
      OFFSET_TRIM_REG_O[15:13] == 3'h0 && !FULL_SCALE_TRIM_REG_O[15])
      else $error("reserved trim bits not zero");
   a_offset_positive: assert property (!$past(OFFSET_TRIM_REG_O[12]) |->
      OFFSET_TRIM_O == $signed({1'b0, $past(OFFSET_TRIM_REG_O[11:0])}))
      else $error("positive offset wrong");
   a_offset_negative: assert property ($past(OFFSET_TRIM_REG_O[12]) |->
      OFFSET_TRIM_O == -$signed({1'b0, $past(OFFSET_TRIM_REG_O[11:0])}))
      else $error("negative offset wrong");
   a_range_follows_reg: assert property (
      FULL_SCALE_RANGE_O == $past(FULL_SCALE_TRIM_REG_O[14:0]))
      else $error("range output does not follow register");
   a_reset_defaults: assert property ($rose(RST_N_I) |->
      OFFSET_TRIM_REG_O == 16'h0000 && FULL_SCALE_TRIM_REG_O == 16'h4000
      && FULL_SCALE_RANGE_O == 15'h4000 && OFFSET_TRIM_O == 13'sh0)
      else $error("bad reset values");
   a_idle_hold: assert property (SCS_N_I [*8] |->
      $stable(OFFSET_TRIM_REG_O) && $stable(FULL_SCALE_TRIM_REG_O))
      else $error("trim register changed while deselected");
   c_negative_offset: cover property (OFFSET_TRIM_O < 0);
   c_range_max: cover property (FULL_SCALE_RANGE_O == 15'h7FFF);
   c_range_min: cover property (FULL_SCALE_RANGE_O == 15'h0000);
endmodule : trim_regs_chk
bind channel_offset_gain_trim_regs trim_regs_chk i_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
   .SCS_N_I(SCS_N_I), .OFFSET_TRIM_O(OFFSET_TRIM_O), .FULL_SCALE_RANGE_O(FULL_SCALE_RANGE_O),
   .OFFSET_TRIM_REG_O(OFFSET_TRIM_REG_O), .FULL_SCALE_TRIM_REG_O(FULL_SCALE_TRIM_REG_O));
`default_nettype wire
